// ===== pkg/startup_cfg_pkg.sv
// Purpose: constants for the motor start-up configuration block
// Assumes: 16-bit words, one per address, on an 8-bit-addressed register port
// Notes: rates are held as fixed-point codes for downstream logic
package startup_cfg_pkg;
	// ************************************************
	// register map
	// ************************************************
	localparam logic [7:0] detect_brake_addr = 8'h92;
	localparam logic [7:0] accel_handover_addr = 8'h93;
	localparam logic [15:0] cfg_reset = 16'h0000;
	localparam logic [15:0] accel_rw_mask = 16'h7FFF;
	// ************************************************
	// field positions
	// ************************************************
	localparam int stationary_pos = 14;
	localparam int brake_level_pos = 13;
	localparam int hysteresis_pos = 12;
	localparam int detect_en_pos = 11;
	localparam int reverse_en_pos = 10;
	localparam int reverse_thr_pos = 8;
	localparam int current_pos = 6;
	localparam int ramp_pos = 3;
	localparam int brake_dur_pos = 0;
	localparam int range_pos = 14;
	localparam int accel2_pos = 11;
	localparam int accel1_pos = 8;
	localparam int handover_pos = 3;
	localparam int align_pos = 0;
	// ************************************************
	// timing
	// ************************************************
	localparam int clk_mhz = 200;
	localparam int ms_tick_ns = 1000000;
	localparam int ms_tick_cycles = ms_tick_ns * clk_mhz / 1000;
	localparam int stationary_base_ms = 80;
	localparam int brake_base_ms = 2700;
	localparam int align_base_ms = 5300;
	// handover speed in units of 0.1 Hz
	localparam int low_step_dhz = 8;
	localparam int high_step_dhz = 128;
	localparam int high_base_dhz = 119;
	typedef enum logic [2:0] {
		st_idle, st_detect, st_brake, st_reverse, st_align, st_open,
		st_closed
	} phase_t;
endpackage

// ===== core/motor_startup_config.sv
// Purpose: start-up configuration words and start-up sequencer
// Assumes: register port is synchronous; speeds in 0.1 Hz units
// Notes: settings latched at a start-up request taken in idle
//Behaviour
//RULE1 - stationary after 80/160/320/640 ms silence
//RULE2 - brake level 24 mA or 48 mA
//RULE3 - comparator hysteresis 20 mV or 40 mV
//RULE4 - speed detection only when enabled
//RULE5 - reverse enable and 6.3-51 Hz threshold
//RULE6 - open-loop current 0.2 to 1.6 A
//RULE7 - align current 0.15 to 1.2 A
//RULE8 - current ramp code 000 fastest
//RULE9 - brake code 000 off, else durations
//RULE10 - range bit selects fast or slow
//RULE11 - second-order accel code, 111 is zero
//RULE12 - first-order accel code per range
//RULE13 - low handover range n times 0.8 Hz
//RULE14 - high handover range 12.8(n-16)+11.9 Hz
//RULE15 - align time 5.3 s halving per code
//RULE16 - reserved top bit reads zero
//RULE17 - both words reset to zero
//RULE18 - detect, brake/reverse/align, open, closed
//RULE19 - new settings apply at next start
`timescale 1ns/10ps
module motor_startup_config (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic start_request,
	input wire logic zero_cross,
	input wire logic [11:0] speed_dhz,
	input wire logic speed_reverse,
	output startup_cfg_pkg::phase_t phase,
	output logic [1:0] drive_current_code,
	output logic align_current_select,
	output logic [2:0] ramp_code,
	output logic brake_level_high,
	output logic hysteresis_high,
	output logic accel_slow_range,
	output logic [2:0] accel2_code,
	output logic [2:0] accel1_code,
	output logic [11:0] handover_dhz,
	output logic handover_valid
);
	import startup_cfg_pkg::*;
	logic rst_s1, rst_s2;
	logic [15:0] detect_brake_cfg, accel_cfg;
	logic [15:0] run_db, run_ac;
	logic [31:0] tick_cnt;
	logic ms_tick;
	logic [12:0] ms_cnt;
	phase_t next_phase;
	// ************************************************
	// reset release
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	// ************************************************
	// register port
	// ************************************************
	wire wr_db = reg_write && reg_addr == detect_brake_addr;
	wire wr_ac = reg_write && reg_addr == accel_handover_addr;
	// words written by software; reset clears every field
	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2) begin
			detect_brake_cfg <= cfg_reset; // [RULE17]
			accel_cfg <= cfg_reset; // [RULE17]
		end else begin
			if (wr_db)
				detect_brake_cfg <= reg_wdata;
			if (wr_ac)
				accel_cfg <= reg_wdata & accel_rw_mask; // [RULE16]
		end
	end
	// read mux, reserved bit held at zero
	assign reg_rdata = (reg_addr == detect_brake_addr) ? detect_brake_cfg :
		(reg_addr == accel_handover_addr) ? accel_cfg : 16'h0000;
	// ************************************************
	// settings snapshot per start-up
	// ************************************************
	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2) begin
			run_db <= cfg_reset;
			run_ac <= cfg_reset;
		end else if (phase == st_idle && start_request) begin
			run_db <= detect_brake_cfg; // [RULE19]
			run_ac <= accel_cfg; // [RULE19]
		end
	end
	// ************************************************
	// field decode of running copy
	// ************************************************
	wire [1:0] stat_code = run_db[stationary_pos +: 2];
	wire detect_en = run_db[detect_en_pos];
	wire reverse_en = run_db[reverse_en_pos];
	wire [1:0] rev_code = run_db[reverse_thr_pos +: 2];
	wire [2:0] brake_code = run_db[brake_dur_pos +: 3];
	wire brake_en = brake_code != 3'h0; // [RULE9]
	wire [4:0] ho_code = run_ac[handover_pos +: 5];
	wire [2:0] align_code = run_ac[align_pos +: 3];
	// reverse or brake speed threshold in 0.1 Hz
	function automatic logic [11:0] rev_thr(input logic [1:0] c);
		case (c)
			2'h0: rev_thr = 12'd63;
			2'h1: rev_thr = 12'd130;
			2'h2: rev_thr = 12'd260;
			default: rev_thr = 12'd510;
		endcase
	endfunction
	wire [11:0] rev_limit = rev_thr(rev_code); // [RULE5]
	// handover speed in 0.1 Hz
	wire [11:0] ho_low = 12'(ho_code[3:0] * low_step_dhz); // [RULE13]
	wire [11:0] ho_high = 12'(ho_code[3:0] * high_step_dhz
		+ high_base_dhz); // [RULE14]
	assign handover_dhz = ho_code[4] ? ho_high : ho_low;
	assign handover_valid = ho_code != 5'h00; // [RULE13]
	// ************************************************
	// pass-through settings, and align current select decoded from phase
	// ************************************************
	assign drive_current_code = run_db[current_pos +: 2]; // [RULE6]
	assign align_current_select = phase == st_align; // [RULE7]
	assign ramp_code = run_db[ramp_pos +: 3]; // [RULE8]
	assign brake_level_high = run_db[brake_level_pos]; // [RULE2]
	assign hysteresis_high = run_db[hysteresis_pos]; // [RULE3]
	assign accel_slow_range = run_ac[range_pos]; // [RULE10]
	assign accel2_code = run_ac[accel2_pos +: 3]; // [RULE11]
	assign accel1_code = run_ac[accel1_pos +: 3]; // [RULE12]
	// ************************************************
	// millisecond tick and phase timer
	// ************************************************
	assign ms_tick = tick_cnt == 32'(ms_tick_cycles - 1);
	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2)
			tick_cnt <= 32'h0;
		else
			tick_cnt <= ms_tick ? 32'h0 : tick_cnt + 32'h1;
	end
	wire phase_change = next_phase != phase;
	// silence timer restarts on a zero cross during detection and on each phase change
	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2)
			ms_cnt <= 13'h0;
		else if (phase_change || (phase == st_detect && zero_cross))
			ms_cnt <= 13'h0;
		else if (ms_tick)
			ms_cnt <= ms_cnt + 13'h1;
	end
	// durations in ms, stationary doubling and brake and align halving per code
	wire [12:0] stat_ms = 13'(stationary_base_ms << stat_code); // [RULE1]
	wire [12:0] brake_ms = 13'(brake_base_ms >> (brake_code - 3'h1));
	wire [12:0] align_ms = 13'(align_base_ms >> align_code); // [RULE15]
	// ************************************************
	// start-up sequence
	// ************************************************
	wire fast = speed_dhz >= rev_limit;
	always_comb begin
		next_phase = phase;
		case (phase)
			st_idle:
				if (start_request)
					next_phase = st_detect;
			st_detect:
				if (!detect_en) // [RULE4]
					next_phase = st_align;
				else if (ms_cnt >= stat_ms) // [RULE1]
					next_phase = brake_en ? st_brake : st_align;
				else if (zero_cross && fast && speed_reverse)
					next_phase = reverse_en ? st_reverse :
						(brake_en ? st_brake : st_align); // [RULE5]
				else if (zero_cross && fast)
					next_phase = st_closed;
			st_brake:
				if (ms_cnt >= brake_ms) // [RULE9]
					next_phase = st_align;
			st_reverse:
				if (speed_dhz < rev_limit)
					next_phase = brake_en ? st_brake : st_align;
			st_align:
				if (ms_cnt >= align_ms) // [RULE15]
					next_phase = st_open;
			st_open:
				if (handover_valid && speed_dhz >= handover_dhz)
					next_phase = st_closed; // [RULE18]
			st_closed:
				next_phase = st_closed;
			default:
				next_phase = st_idle;
		endcase
	end
	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2)
			phase <= st_idle;
		else
			phase <= next_phase; // [RULE18]
	end
	// ************************************************
	// checks
	// ************************************************
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_s2)
		reg_addr == accel_handover_addr |-> !reg_rdata[15]) // [RULE16]
		else $error("reserved bit read as one");
	a_snapshot_hold: assert property (@(posedge clk) disable iff (!rst_s2)
		phase != st_idle |=> $stable(run_db)) // [RULE19]
		else $error("settings changed mid sequence");
	a_skip_detect: assert property (@(posedge clk) disable iff (!rst_s2)
		phase == st_detect && !detect_en |=> phase == st_align) // [RULE4]
		else $error("detection not skipped");
	a_no_brake: assert property (@(posedge clk) disable iff (!rst_s2)
		phase != st_brake && brake_code == 3'h0 |=> phase != st_brake)
		// [RULE9]
		else $error("brake entered while disabled");
	a_align_to_open: assert property (@(posedge clk) disable iff (!rst_s2)
		phase == st_align && ms_cnt >= align_ms |=> phase == st_open)
		// [RULE15]
		else $error("align did not end");
	a_handover_step: assert property (@(posedge clk) disable iff (!rst_s2)
		!ho_code[4] |-> handover_dhz == 12'(ho_code * 8)) // [RULE13]
		else $error("low handover wrong");
	a_handover_high: assert property (@(posedge clk) disable iff (!rst_s2)
		ho_code == 5'h1F |-> handover_dhz == 12'd2039) // [RULE14]
		else $error("high handover wrong");
	a_open_close: assert property (@(posedge clk) disable iff (!rst_s2)
		phase == st_open && handover_valid && speed_dhz >= handover_dhz
		|=> phase == st_closed) // [RULE18]
		else $error("handover missed");
	a_stationary: assert property (@(posedge clk) disable iff (!rst_s2)
		phase == st_detect && detect_en |-> stat_ms == 13'(80 << stat_code))
		// [RULE1]
		else $error("stationary time wrong");
	a_reset_zero: assert property (@(posedge clk)
		$rose(rst_s2) |-> detect_brake_cfg == 16'h0000) // [RULE17]
		else $error("word not cleared");
	// ************************************************
	// checks of the sequence and held settings
	// ************************************************
	// a start request in idle opens detection and takes a snapshot
	a_start_detect: assert property (@(posedge clk) // [RULE18]
		disable iff (!rst_s2) phase == st_idle && start_request
		|=> phase == st_detect)
		else $error("start not taken");
	a_start_snap: assert property (@(posedge clk) // [RULE19]
		disable iff (!rst_s2) phase == st_idle && start_request
		|=> run_db == $past(detect_brake_cfg) && run_ac == $past(accel_cfg))
		else $error("snapshot not taken");
	a_level_hold: assert property (@(posedge clk) // [RULE2]
		disable iff (!rst_s2) phase != st_idle |=> $stable(brake_level_high))
		else $error("brake level changed mid sequence");
	a_hyst_hold: assert property (@(posedge clk) // [RULE3]
		disable iff (!rst_s2) phase != st_idle |=> $stable(hysteresis_high))
		else $error("hysteresis changed mid sequence");
	a_current_hold: assert property (@(posedge clk) // [RULE6]
		disable iff (!rst_s2) phase != st_idle |=> $stable(drive_current_code))
		else $error("current changed mid sequence");
	a_ramp_hold: assert property (@(posedge clk) // [RULE8]
		disable iff (!rst_s2) phase != st_idle |=> $stable(ramp_code))
		else $error("ramp changed mid sequence");
	a_range_hold: assert property (@(posedge clk) // [RULE10]
		disable iff (!rst_s2) phase != st_idle |=> $stable(accel_slow_range))
		else $error("range changed mid sequence");
	a_accel2_hold: assert property (@(posedge clk) // [RULE11]
		disable iff (!rst_s2) phase != st_idle |=> $stable(accel2_code))
		else $error("second order accel changed mid sequence");
	a_accel1_hold: assert property (@(posedge clk) // [RULE12]
		disable iff (!rst_s2) phase != st_idle |=> $stable(accel1_code))
		else $error("first order accel changed mid sequence");
	a_handover_hold: assert property (@(posedge clk) // [RULE13]
		disable iff (!rst_s2) phase != st_idle |=> $stable(handover_dhz))
		else $error("handover changed mid sequence");
	a_align_select: assert property (@(posedge clk) // [RULE7]
		disable iff (!rst_s2) align_current_select |-> phase == st_align)
		else $error("align current outside align");
	a_accel_reset: assert property (@(posedge clk) // [RULE17]
		$rose(rst_s2) |-> accel_cfg == 16'h0000 && phase == st_idle)
		else $error("accel word or phase not cleared");
	a_write_mask: assert property (@(posedge clk) // [RULE16]
		disable iff (!rst_s2) wr_ac |=> !accel_cfg[15])
		else $error("reserved bit stored");
	a_reverse_entry: assert property (@(posedge clk) // [RULE5]
		disable iff (!rst_s2) phase == st_detect && detect_en
		&& ms_cnt < stat_ms && zero_cross && speed_reverse && reverse_en
		&& speed_dhz >= rev_limit |=> phase == st_reverse)
		else $error("reverse drive not entered");
	a_reverse_exit: assert property (@(posedge clk) // [RULE5]
		disable iff (!rst_s2) phase == st_reverse && speed_dhz < rev_limit
		|=> phase != st_reverse)
		else $error("reverse drive not left");
	a_brake_exit: assert property (@(posedge clk) // [RULE9]
		disable iff (!rst_s2) phase == st_brake && ms_cnt >= brake_ms
		|=> phase == st_align)
		else $error("brake did not end");
	a_stat_exit: assert property (@(posedge clk) // [RULE1]
		disable iff (!rst_s2) phase == st_detect && detect_en
		&& ms_cnt >= stat_ms |=> phase == st_brake || phase == st_align)
		else $error("stationary motor not handled");
	a_silence_restart: assert property (@(posedge clk) // [RULE1]
		disable iff (!rst_s2) phase == st_detect && zero_cross
		|=> ms_cnt == 13'h0)
		else $error("silence timer not restarted");
	a_handover_none: assert property (@(posedge clk) // [RULE13]
		disable iff (!rst_s2) ho_code == 5'h00 |-> !handover_valid)
		else $error("zero handover code marked valid");
	a_handover_base: assert property (@(posedge clk) // [RULE14]
		disable iff (!rst_s2) ho_code == 5'h10 |-> handover_dhz == 12'd119)
		else $error("high handover base wrong");
endmodule

// ===== testbench/motor_windings_model.sv
// Purpose: rotor and windings as seen by the back-EMF sensing
// Assumes: bench sets the wanted motion between clock edges
// Notes: outputs move on the rising edge, one cycle behind
`timescale 1ns/10ps
module motor_windings_model (
	input wire logic clk,
	input wire logic [11:0] spin_dhz,
	input wire logic spin_back,
	input wire logic cross_now,
	output logic zero_cross,
	output logic [11:0] speed_dhz,
	output logic speed_reverse
);
	// ************************************************
	// rotor state presented to the sensing logic
	// ************************************************
	always_ff @(posedge clk) begin
		zero_cross <= cross_now; // one pulse per request
		speed_dhz <= spin_dhz;
		speed_reverse <= spin_back;
	end
endmodule

// ===== testbench/tb_motor_startup_config.sv
// Purpose: random and corner checks of the start-up configuration
// Assumes: ms timers too long to expire; phases checked early
// Notes: each pass resets, programs, starts, then rewrites
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
$display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_motor_startup_config;
	import startup_cfg_pkg::*;
	logic clk = 0, rst_n = 0, reg_write = 0, start_request = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd, w3, w4;
	logic [11:0] spin = 12'h000, speed_dhz, handover_dhz;
	logic back = 0, cross_now = 0, zero_cross, speed_reverse;
	logic align_current_select, brake_level_high, hysteresis_high;
	logic accel_slow_range, handover_valid;
	logic [1:0] drive_current_code;
	logic [2:0] ramp_code, accel2_code, accel1_code;
	phase_t phase, ep;
	int seed = 70, fails = 0, n_checks = 0, cycles = 0, i;
	// ************************************************
	// design, motor and clock
	// ************************************************
	motor_startup_config u_motor_startup_config (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .start_request(start_request),
		.zero_cross(zero_cross), .speed_dhz(speed_dhz),
		.speed_reverse(speed_reverse), .phase(phase),
		.drive_current_code(drive_current_code),
		.align_current_select(align_current_select), .ramp_code(ramp_code),
		.brake_level_high(brake_level_high),
		.hysteresis_high(hysteresis_high),
		.accel_slow_range(accel_slow_range), .accel2_code(accel2_code),
		.accel1_code(accel1_code), .handover_dhz(handover_dhz),
		.handover_valid(handover_valid));
	motor_windings_model u_motor_windings_model (.clk(clk),
		.spin_dhz(spin), .spin_back(back), .cross_now(cross_now),
		.zero_cross(zero_cross), .speed_dhz(speed_dhz),
		.speed_reverse(speed_reverse));
	always #2.5 clk = ~clk;
	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_sim;
		end
	end
	// ************************************************
	// expectations
	// ************************************************
	function automatic logic [11:0] rev_thr(logic [1:0] c);
		case (c)
			2'h0: return 12'd63;
			2'h1: return 12'd130;
			2'h2: return 12'd260;
			default: return 12'd510;
		endcase
	endfunction
	function automatic logic [11:0] exp_ho(logic [4:0] n);
		if (n[4]) return 12'd119 + {1'b0, n[3:0], 7'h00};
		return {5'h00, n[3:0], 3'h0};
	endfunction
	function automatic phase_t exp_ph(logic [15:0] c, logic [11:0] s,
		logic b);
		if (!c[11]) return st_align;
		if (s < rev_thr(c[9:8])) return st_detect;
		if (!b) return st_closed;
		if (c[10]) return st_reverse;
		return (c[2:0] != 3'h0) ? st_brake : st_align;
	endfunction
	// ************************************************
	// register port and closing
	// ************************************************
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1;
		@(negedge clk);
		reg_write = 0;
	endtask
	task automatic rdw(logic [7:0] a);
		@(negedge clk);
		reg_addr = a;
		#1 rd = reg_rdata;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		rdw(detect_brake_addr);
		`CHK("word3 reset", 16'h0000, rd)
		rdw(accel_handover_addr);
		`CHK("word4 reset", 16'h0000, rd)
		`CHK("phase reset", st_idle, phase)
		wr(8'h94, 16'hFFFF);
		rdw(8'h94);
		`CHK("unmapped", 16'h0000, rd)
		for (i = 0; i < 40; i++) begin
			w3 = 16'($random(seed));
			w4 = 16'($random(seed));
			spin = {3'h0, 9'($random(seed))};
			back = 1'($random(seed));
			if (i == 0) begin
				w4[7:3] = 5'h00;
				w3[11:10] = 2'h3;
				spin = rev_thr(w3[9:8]);
				back = 1;
			end
			if (i == 1) begin
				w4[7:3] = 5'h10;
				w3[11] = 1;
				spin = rev_thr(w3[9:8]) - 12'h001;
			end
			if (i == 2) begin
				w4[7:3] = 5'h1F;
				w3[11:10] = 2'h2;
				w3[2:0] = 3'h0;
				back = 1;
				spin = 12'h1FF;
			end
			rst_n = 0;
			@(negedge clk);
			rst_n = 1;
			repeat (3) @(negedge clk);
			wr(detect_brake_addr, w3);
			wr(accel_handover_addr, w4);
			rdw(detect_brake_addr);
			`CHK("word3", w3, rd)
			rdw(accel_handover_addr);
			`CHK("word4", w4 & 16'h7FFF, rd)
			@(negedge clk);
			start_request = 1;
			@(negedge clk);
			start_request = 0;
			`CHK("phase start", st_detect, phase)
			@(negedge clk);
			ep = w3[11] ? st_detect : st_align;
			`CHK("phase detect", ep, phase)
			cross_now = 1;
			@(negedge clk);
			cross_now = 0;
			wr(detect_brake_addr, ~w3);
			wr(accel_handover_addr, ~w4);
			ep = exp_ph(w3, spin, back);
			`CHK("phase cross", ep, phase)
			`CHK("align sel", ep == st_align, align_current_select)
			`CHK("word3 fields", {w3[13:12], w3[7:3]}, {brake_level_high,
				hysteresis_high, drive_current_code, ramp_code})
			`CHK("level bits", w3[13:12], {brake_level_high,
				hysteresis_high})
			`CHK("current", w3[7:3], {drive_current_code,
				ramp_code})
			`CHK("accel", w4[14:8], {accel_slow_range, accel2_code,
				accel1_code})
			`CHK("handover", {w4[7:3] != 5'h00, exp_ho(w4[7:3])},
				{handover_valid, handover_dhz})
			rdw(detect_brake_addr);
			`CHK("word3 new", ~w3, rd)
		end
		end_sim;
	end
endmodule
